// File: src/eep_bus_if.sv
// Two-wire link between controller end and EEPROM end.
// Both lines are open drain with a pull-up; levels resolved here.
interface eep_bus_if;

	logic scl_ctl_o;
	logic scl_ctl_oe;
	logic sda_ctl_o;
	logic sda_ctl_oe;
	logic sda_dev_o;
	logic sda_dev_oe;
	logic scl;
	logic sda;

	// Wired-and with pull-up
	assign scl = ~scl_ctl_oe | scl_ctl_o;
	assign sda = (~sda_ctl_oe | sda_ctl_o) & (~sda_dev_oe | sda_dev_o);

	modport ctl (
		output scl_ctl_o,
		output scl_ctl_oe,
		output sda_ctl_o,
		output sda_ctl_oe,
		input  scl,
		input  sda
	);

	modport dev (
		output sda_dev_o,
		output sda_dev_oe,
		input  scl,
		input  sda
	);

endinterface

// File: src/eep_ctl.sv
// Controller end: write-data FIFO and two-wire bus sequencer.
// Assumes the EEPROM end is the only other driver on the link.
module eep_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 8
) (
	// Clock and reset
	input  wire logic             ref_clk_in,
	input  wire logic             reset_n_in,
	input  wire logic             ce_in,
	// Fill side
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	// Drain side
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic [WIDTH-1:0]      out_data_out
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      wr_ptr_q;
	logic [AW:0]      rd_ptr_q;
	logic             full;
	logic             empty;

	assign full  = (wr_ptr_q[AW] != rd_ptr_q[AW])
		& (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
	assign empty = wr_ptr_q == rd_ptr_q;
	assign in_ready_out  = ~full;
	assign out_valid_out = ~empty;
	assign out_data_out  = mem_q[rd_ptr_q[AW-1:0]];

	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end
		else if (ce_in)
		begin
			if (in_valid_in & ~full)
				wr_ptr_q <= wr_ptr_q + (AW + 1)'(1);
			if (out_ready_in & ~empty)
				rd_ptr_q <= rd_ptr_q + (AW + 1)'(1);
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (ce_in & in_valid_in & ~full)
			mem_q[wr_ptr_q[AW-1:0]] <= in_data_in;
	end

endmodule

module eep_ctl (
	// Clock and reset
	input  wire logic                       ref_clk_in,
	input  wire logic                       reset_n_in,
	input  wire logic                       ce_in,
	// Command
	input  wire logic                       cmd_valid_in,
	output logic                            cmd_ready_out,
	input  wire logic                       cmd_read_in,
	input  wire logic                       cmd_id_in,
	input  wire logic [eep_pkg::CS_W-1:0]   cmd_cs_in,
	input  wire logic [eep_pkg::ADDR_W-1:0] cmd_addr_in,
	input  wire logic [7:0]                 cmd_len_in,
	// Write data
	input  wire logic                       wr_valid_in,
	output logic                            wr_ready_out,
	input  wire logic [7:0]                 wr_data_in,
	// Read data and status
	output logic                            rd_valid_out,
	output logic [7:0]                      rd_data_out,
	output logic                            done_out,
	output logic                            nack_out,
	// Two-wire link
	eep_bus_if.ctl                          link_io
);
	import eep_pkg::*;

	localparam int unsigned QW = $clog2(QTR_CYCLES);

	logic [1:0]        sda_sy_q;
	eep_cst_type       st_q;
	logic [QW-1:0]     qcnt_q;
	logic [1:0]        ph_q;
	logic [3:0]        bit_q;
	logic [7:0]        tx_q;
	logic [7:0]        rx_q;
	logic [7:0]        len_q;
	logic [9:0]        poll_q;
	logic [CS_W-1:0]   cs_q;
	logic [ADDR_W-1:0] addr_q;
	logic              ack_q;
	logic              scl_q;
	logic              oe_q;
	logic              rd_q;
	logic              id_q;
	logic              retry_q;
	logic              fail_q;
	logic              act_q;
	logic              rec_ok_q;
	logic              rdv_q;
	logic              done_q;
	logic [7:0]        rdd_q;

	logic              sda_s;
	logic              f_valid;
	logic [7:0]        f_data;
	logic              f_first;
	logic              stall;
	logic              step;
	logic              last;
	logic              f_pop;
	logic              tx_bit;

	eep_fifo #(
		.WIDTH (BYTE_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.ref_clk_in    (ref_clk_in),
		.reset_n_in    (reset_n_in),
		.ce_in         (ce_in),
		.in_valid_in   (wr_valid_in),
		.in_ready_out  (wr_ready_out),
		.in_data_in    (wr_data_in),
		.out_valid_out (f_valid),
		.out_ready_in  (f_pop),
		.out_data_out  (f_data)
	);

	assign sda_s   = sda_sy_q[1];
	assign f_first = (st_q == C_WDATA) & (bit_q == 4'h0) & (ph_q == 2'h0);
	assign stall   = f_first & ~f_valid;
	assign step    = ce_in & (qcnt_q == QW'(QTR_CYCLES - 1))
		& (st_q != C_IDLE) & ~stall;
	assign f_pop   = step & f_first;
	assign last    = len_q == 8'h01;
	assign tx_bit  = f_first ? f_data[7] : tx_q[7];

	// Quarter-bit timebase and data line synchroniser
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			qcnt_q   <= '0;
			sda_sy_q <= 2'b11;
		end
		else if (ce_in)
		begin
			sda_sy_q <= {sda_sy_q[0], link_io.sda};
			if (qcnt_q == QW'(QTR_CYCLES - 1))
				qcnt_q <= '0;
			else
				qcnt_q <= qcnt_q + QW'(1);
		end
	end

	// Bus sequencer
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			st_q     <= C_RECOVER;
			ph_q     <= 2'h0;
			bit_q    <= 4'h0;
			tx_q     <= 8'hff;
			rx_q     <= 8'h00;
			len_q    <= 8'h00;
			poll_q   <= 10'h000;
			cs_q     <= '0;
			addr_q   <= 16'h0000;
			ack_q    <= 1'b0;
			scl_q    <= 1'b1;
			oe_q     <= 1'b0;
			rd_q     <= 1'b0;
			id_q     <= 1'b0;
			retry_q  <= 1'b0;
			fail_q   <= 1'b0;
			act_q    <= 1'b0;
			rec_ok_q <= 1'b0;
			rdv_q    <= 1'b0;
			done_q   <= 1'b0;
			rdd_q    <= 8'h00;
		end
		else if (ce_in)
		begin
			rdv_q  <= 1'b0;
			done_q <= 1'b0;
			if ((st_q == C_IDLE) & cmd_valid_in)
			begin
				st_q    <= C_START;
				ph_q    <= 2'h0;
				bit_q   <= 4'h0;
				poll_q  <= 10'h000;
				fail_q  <= 1'b0;
				retry_q <= 1'b0;
				act_q   <= 1'b1;
				rd_q    <= cmd_read_in;
				id_q    <= cmd_id_in;
				cs_q    <= cmd_cs_in;
				addr_q  <= cmd_addr_in;
				len_q   <= cmd_len_in;
			end
			else if (step)
			begin
				ph_q <= ph_q + 2'h1;
				case (st_q)
				C_RECOVER:
				begin
					case (ph_q)
					2'h0: oe_q <= 1'b0;
					2'h1: scl_q <= 1'b1;
					2'h2: rec_ok_q <= sda_s;
					default:
					begin
						scl_q <= 1'b0;
						bit_q <= bit_q + 4'h1;
						if (rec_ok_q | (bit_q == BIT_ACK))
						begin
							st_q  <= C_STOP;
							bit_q <= 4'h0;
						end
					end
					endcase
				end
				C_START, C_RSTART:
				begin
					case (ph_q)
					2'h0: oe_q <= 1'b0;
					2'h1: scl_q <= 1'b1;
					2'h2: oe_q <= 1'b1;
					default:
					begin
						scl_q <= 1'b0;
						bit_q <= 4'h0;
						st_q  <= (st_q == C_START) ? C_DEV : C_RDEV;
						tx_q  <= eep_dev_word(id_q, cs_q,
							st_q == C_RSTART);
					end
					endcase
				end
				C_STOP:
				begin
					case (ph_q)
					2'h0:
					begin
						scl_q <= 1'b0;
						oe_q  <= 1'b1;
					end
					2'h1: scl_q <= 1'b1;
					2'h2: oe_q <= 1'b0;
					default:
					begin
						retry_q <= 1'b0;
						if (retry_q & ~fail_q)
							st_q <= C_START;
						else
						begin
							st_q   <= C_IDLE;
							done_q <= act_q;
							act_q  <= 1'b0;
						end
					end
					endcase
				end
				default:
				begin
					case (ph_q)
					2'h0:
					begin
						scl_q <= 1'b0;
						if (f_first)
							tx_q <= f_data;
						if (bit_q != BIT_ACK)
							oe_q <= ~tx_bit;
						else
							oe_q <= (st_q == C_RDATA) & ~last;
					end
					2'h1: scl_q <= 1'b1;
					2'h2:
					begin
						if (bit_q != BIT_ACK)
							rx_q <= {rx_q[6:0], sda_s};
						else
							ack_q <= ~sda_s;
					end
					default:
					begin
						scl_q <= 1'b0;
						tx_q  <= {tx_q[6:0], 1'b1};
						bit_q <= bit_q + 4'h1;
						if (bit_q == BIT_ACK)
						begin
							bit_q <= 4'h0;
							if (st_q == C_RDATA)
							begin
								rdv_q <= 1'b1;
								rdd_q <= rx_q;
								len_q <= len_q - 8'h01;
								tx_q  <= 8'hff;
								if (last)
									st_q <= C_STOP;
							end
							else if (~ack_q)
							begin
								st_q <= C_STOP;
								if (st_q == C_DEV)
								begin
									retry_q <= 1'b1;
									poll_q  <= poll_q + 10'h001;
									fail_q  <= poll_q == POLL_LIMIT;
								end
								else
									fail_q <= 1'b1;
							end
							else
							begin
								case (st_q)
								C_DEV:
								begin
									st_q <= C_AHI;
									tx_q <= addr_q[15:8];
								end
								C_AHI:
								begin
									st_q <= C_ALO;
									tx_q <= addr_q[7:0];
								end
								C_ALO:
								begin
									st_q <= rd_q ? C_RSTART : C_WDATA;
									tx_q <= 8'hff;
								end
								C_RDEV:
								begin
									st_q <= C_RDATA;
									tx_q <= 8'hff;
								end
								default:
								begin
									len_q <= len_q - 8'h01;
									if (last)
										st_q <= C_STOP;
								end
								endcase
							end
						end
					end
					endcase
				end
				endcase
			end
		end
	end

	assign cmd_ready_out      = st_q == C_IDLE;
	assign rd_valid_out       = rdv_q;
	assign rd_data_out        = rdd_q;
	assign done_out           = done_q;
	assign nack_out           = fail_q;
	assign link_io.scl_ctl_o  = 1'b0;
	assign link_io.scl_ctl_oe = ~scl_q;
	assign link_io.sda_ctl_o  = 1'b0;
	assign link_io.sda_ctl_oe = oe_q;

endmodule

// File: src/eep_dev.sv
// EEPROM end: two-wire target with page latch, array and ID page.
// Assumes link lines and straps are asynchronous to ref_clk_in.
module eep_dev #(
	parameter int unsigned PROG_CYCLES = eep_pkg::PROG_CYCLES_DFLT
) (
	// Clock and reset
	input  wire logic                     ref_clk_in,
	input  wire logic                     reset_n_in,
	input  wire logic                     ce_in,
	// Straps and protect pin
	input  wire logic [eep_pkg::CS_W-1:0] strap_in,
	input  wire logic                     wp_in,
	// Status
	output logic                          standby_out,
	output logic                          busy_out,
	output logic                          id_locked_out,
	// Two-wire link
	eep_bus_if.dev                        link_io
);
	import eep_pkg::*;

	localparam int unsigned PW = $clog2(PROG_CYCLES + 1);
	localparam int unsigned SW = CS_W + 3;
	localparam logic [SW-1:0] SYNC_RST = {2'b11, {(SW-2){1'b0}}};

	logic [SW-1:0]       sync1_q;
	logic [SW-1:0]       sync2_q;
	logic                scl_p_q;
	logic                sda_p_q;
	eep_dst_type         st_q;
	logic [3:0]          cnt_q;
	logic                ackph_q;
	logic                oe_q;
	logic                rd_q;
	logic                idsel_q;
	logic                mack_q;
	logic                loaded_q;
	logic                lockreq_q;
	logic                locked_q;
	logic                busy_q;
	logic                prog_id_q;
	logic [7:0]          sh_q;
	logic [7:0]          tx_q;
	logic [ADDR_W-1:0]   addr_q;
	logic [PW-1:0]       pcnt_q;
	logic [PAGE_BYTES-1:0] valid_q;
	logic [7:0]          page_q [PAGE_BYTES];
	logic [7:0]          mem_q  [MEM_WORDS];
	logic [7:0]          idp_q  [PAGE_BYTES];

	logic                scl_s;
	logic                sda_s;
	logic                wp_s;
	logic [CS_W-1:0]     strap_s;
	logic                scl_rise;
	logic                scl_fall;
	logic                start_det;
	logic                stop_det;
	logic                byte_end;
	logic                ack_end;
	logic                dev_ack;
	logic                lock_cmd;
	logic                data_ack;
	logic                page_we;
	logic                prog_go;
	logic                load_rd;
	logic                commit;
	logic [OFS_W-1:0]    cofs;
	logic [7:0]          rd_byte;
	logic [ADDR_W-1:0]   rd_next;

	assign scl_s     = sync2_q[SW-1];
	assign sda_s     = sync2_q[SW-2];
	assign wp_s      = sync2_q[CS_W];
	assign strap_s   = sync2_q[CS_W-1:0];
	assign scl_rise  = scl_s & ~scl_p_q;
	assign scl_fall  = ~scl_s & scl_p_q;
	assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;
	assign byte_end  = scl_fall & (cnt_q == BIT_ACK) & ~ackph_q;
	assign ack_end   = scl_fall & ackph_q;
	assign dev_ack   = ((sh_q[7:4] == TYPE_ARRAY) | (sh_q[7:4] == TYPE_ID))
		& (sh_q[3:1] == strap_s) & ~busy_q;
	assign lock_cmd  = idsel_q & addr_q[LOCK_ADDR_BIT];
	assign data_ack  = ~idsel_q | lock_cmd | ~locked_q;
	assign page_we   = ce_in & byte_end & (st_q == D_WDATA) & data_ack
		& ~lock_cmd;
	assign prog_go   = stop_det & loaded_q & ~wp_s & ~busy_q;
	assign load_rd   = ack_end & (((st_q == D_DEVADDR) & rd_q)
		| ((st_q == D_RDATA) & mack_q));
	assign cofs      = pcnt_q[OFS_W-1:0];
	assign commit    = busy_q & (pcnt_q < PW'(PAGE_BYTES)) & valid_q[cofs];
	assign rd_byte   = idsel_q ? idp_q[addr_q[OFS_W-1:0]] : mem_q[addr_q];
	assign rd_next   = idsel_q ? eep_ofs_inc(addr_q)
		: addr_q + 16'h0001;

	// Pin synchronisers and edge history
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			sync1_q <= SYNC_RST;
			sync2_q <= SYNC_RST;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end
		else if (ce_in)
		begin
			sync1_q <= {link_io.scl, link_io.sda, wp_in, strap_in};
			sync2_q <= sync1_q;
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	// Protocol engine
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			st_q      <= D_IDLE;
			cnt_q     <= 4'h0;
			ackph_q   <= 1'b0;
			oe_q      <= 1'b0;
			rd_q      <= 1'b0;
			idsel_q   <= 1'b0;
			mack_q    <= 1'b0;
			loaded_q  <= 1'b0;
			lockreq_q <= 1'b0;
			locked_q  <= 1'b0;
			sh_q      <= 8'h00;
			tx_q      <= 8'h00;
			addr_q    <= 16'h0000;
		end
		else if (ce_in)
		begin
			if (start_det)
			begin
				st_q    <= D_DEVADDR;
				cnt_q   <= 4'h0;
				ackph_q <= 1'b0;
				oe_q    <= 1'b0;
			end
			else if (stop_det)
			begin
				st_q      <= D_IDLE;
				oe_q      <= 1'b0;
				loaded_q  <= 1'b0;
				lockreq_q <= 1'b0;
				if (lockreq_q & ~wp_s)
					locked_q <= 1'b1;
			end
			else if (st_q != D_IDLE)
			begin
				if (scl_rise & (cnt_q != BIT_ACK))
				begin
					sh_q  <= {sh_q[6:0], sda_s};
					cnt_q <= cnt_q + 4'h1;
				end
				if (scl_rise & (cnt_q == BIT_ACK))
					mack_q <= ~sda_s;
				if (byte_end)
				begin
					ackph_q <= 1'b1;
					case (st_q)
					D_DEVADDR:
					begin
						if (dev_ack)
						begin
							oe_q    <= 1'b1;
							idsel_q <= (sh_q[7:4] == TYPE_ID);
							rd_q    <= sh_q[0];
						end
						else
							st_q <= D_IDLE;
					end
					D_ADDR_HI:
					begin
						addr_q[15:8] <= sh_q;
						oe_q         <= 1'b1;
					end
					D_ADDR_LO:
					begin
						addr_q[7:0] <= sh_q;
						oe_q        <= 1'b1;
					end
					D_WDATA:
					begin
						oe_q <= data_ack;
						if (lock_cmd)
							lockreq_q <= sh_q[LOCK_DATA_BIT];
						else if (data_ack)
						begin
							addr_q   <= eep_ofs_inc(addr_q);
							loaded_q <= 1'b1;
						end
					end
					default:
						oe_q <= 1'b0;
					endcase
				end
				else if (ack_end)
				begin
					ackph_q <= 1'b0;
					cnt_q   <= 4'h0;
					oe_q    <= 1'b0;
					if (load_rd)
					begin
						st_q   <= D_RDATA;
						tx_q   <= rd_byte;
						oe_q   <= ~rd_byte[7];
						addr_q <= rd_next;
					end
					else
					begin
						case (st_q)
						D_DEVADDR: st_q <= D_ADDR_HI;
						D_ADDR_HI: st_q <= D_ADDR_LO;
						D_ADDR_LO: st_q <= D_WDATA;
						D_WDATA:   st_q <= D_WDATA;
						default:   st_q <= D_IDLE;
						endcase
					end
				end
				else if (scl_fall & (st_q == D_RDATA))
				begin
					tx_q <= {tx_q[6:0], 1'b0};
					oe_q <= ~tx_q[6];
				end
			end
		end
	end

	// Page latch occupancy
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			valid_q <= '0;
		else if (ce_in & byte_end & (st_q == D_ADDR_LO))
			valid_q <= '0;
		else if (page_we)
			valid_q[addr_q[OFS_W-1:0]] <= 1'b1;
	end

	// Self-timed programming cycle
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			busy_q    <= 1'b0;
			prog_id_q <= 1'b0;
			pcnt_q    <= '0;
		end
		else if (ce_in)
		begin
			if (prog_go)
			begin
				busy_q    <= 1'b1;
				prog_id_q <= idsel_q;
				pcnt_q    <= '0;
			end
			else if (busy_q)
			begin
				if (pcnt_q == PW'(PROG_CYCLES - 1))
					busy_q <= 1'b0;
				else
					pcnt_q <= pcnt_q + PW'(1);
			end
		end
	end

	// Storage
	always_ff @(posedge ref_clk_in)
	begin
		if (page_we)
			page_q[addr_q[OFS_W-1:0]] <= sh_q;
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (ce_in & commit & ~prog_id_q)
			mem_q[{addr_q[ADDR_W-1:OFS_W], cofs}] <= page_q[cofs];
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (ce_in & commit & prog_id_q)
			idp_q[cofs] <= page_q[cofs];
	end

	assign standby_out        = (st_q == D_IDLE) & ~busy_q;
	assign busy_out           = busy_q;
	assign id_locked_out      = locked_q;
	assign link_io.sda_dev_o  = 1'b0;
	assign link_io.sda_dev_oe = oe_q;

endmodule

// File: src/eep_pkg.sv
// Shared constants, types and helpers for the two-wire EEPROM link ends.
// Assumes one 100 MHz clock on both ends and an external pull-up model.
// Functional notes
// - Data changes only while clock low
// - Sample on rising, drive after falling clock
// - Start: data falls, clock high, any state
// - Stop: data rises, clock high; standby after
// - Acknowledge each received byte low, ninth clock
// - Standby at power-up and after finished stop
// - Controller recovers: up to nine clocks, start; the sequencer sends a stop instead
// - 512 pages of 128 bytes, 16-bit address
// - Address word type code must match
// - Three select bits match strapped pins
// - Eighth address bit: high read, low write
// - Match acknowledges; mismatch no ack, standby
// - Protect pin high blocks all array writes
// - Byte write: two address bytes, data, stop
// - Programming after stop, bounded, inputs ignored
// - Page write up to 128 bytes, stop
// - Page offset increments and wraps within page
// - Identification page write: type 1011b, lock bit zero
// - Locked identification page: data not acknowledged
// - Polling acknowledged only after programming ends
// - Address counter holds last address plus one
// - Reads continue while controller acknowledges
package eep_pkg;

	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned PROG_TIME_MS  = 5;
	localparam int unsigned SCL_PERIOD_NS = 2500;
	localparam int unsigned QTR_CYCLES    = SCL_PERIOD_NS
		/ (4 * CLK_PERIOD_NS);
	localparam int unsigned PROG_CYCLES_DFLT = PROG_TIME_MS * 1000000
		/ CLK_PERIOD_NS;

	localparam int unsigned BYTE_W     = 8;
	localparam int unsigned ADDR_W     = 16;
	localparam int unsigned OFS_W      = 7;
	localparam int unsigned CS_W       = 3;
	localparam int unsigned PAGE_BYTES = 128;
	localparam int unsigned MEM_WORDS  = 65536;
	localparam int unsigned FIFO_DEPTH = 8;
	localparam int unsigned LOCK_ADDR_BIT = 10;
	localparam int unsigned LOCK_DATA_BIT = 1;

	localparam logic [3:0] TYPE_ARRAY = 4'ha;
	localparam logic [3:0] TYPE_ID    = 4'hb;
	localparam logic [3:0] BIT_ACK    = 4'h8;
	localparam logic [9:0] POLL_LIMIT = 10'h3ff;

	typedef enum logic [2:0] {
		D_IDLE,
		D_DEVADDR,
		D_ADDR_HI,
		D_ADDR_LO,
		D_WDATA,
		D_RDATA
	} eep_dst_type;

	typedef enum logic [3:0] {
		C_RECOVER,
		C_IDLE,
		C_START,
		C_DEV,
		C_AHI,
		C_ALO,
		C_WDATA,
		C_RSTART,
		C_RDEV,
		C_RDATA,
		C_STOP
	} eep_cst_type;

	// Address word: type code, select bits, read flag
	function automatic logic [7:0] eep_dev_word(
		input logic            id,
		input logic [CS_W-1:0] cs,
		input logic            rd
	);
		eep_dev_word = {(id ? TYPE_ID : TYPE_ARRAY), cs, rd};
	endfunction

	// Offset increment that stays inside the page
	function automatic logic [ADDR_W-1:0] eep_ofs_inc(
		input logic [ADDR_W-1:0] a
	);
		eep_ofs_inc = {a[ADDR_W-1:OFS_W], a[OFS_W-1:0] + 7'h01};
	endfunction

endpackage

// File: testbench/eep_asserts.sv
// Checker on the two-wire link between the two ends.
// Assumes open-drain lines resolved inside the interface.
module eep_asserts (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	// Link lines
	input wire logic scl_ctl_o,
	input wire logic scl_ctl_oe,
	input wire logic sda_ctl_o,
	input wire logic sda_ctl_oe,
	input wire logic sda_dev_o,
	input wire logic sda_dev_oe,
	input wire logic scl,
	input wire logic sda
);
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!reset_n_in);

	property p_open_drain;
		!scl_ctl_o && !sda_ctl_o && !sda_dev_o;
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("link driven high");
	property p_dev_low;
		$changed(sda_dev_oe) |-> !scl;
	endproperty
	a_dev_low: assert property (p_dev_low)
		else $error("data moved with clock high");
	property p_dev_fall;
		$changed(sda_dev_oe) |-> !$past(scl, 2);
	endproperty
	a_dev_fall: assert property (p_dev_fall)
		else $error("data moved before clock fall");
	property p_scl_high;
		$rose(scl) |-> scl[*8];
	endproperty
	a_scl_high: assert property (p_scl_high)
		else $error("clock high too short");
	property p_no_clash;
		sda_dev_oe && sda_ctl_oe |-> !scl;
	endproperty
	a_no_clash: assert property (p_no_clash)
		else $error("both ends drive data");
	property p_dev_hold;
		$rose(sda_dev_oe) |=> sda_dev_oe[*8];
	endproperty
	a_dev_hold: assert property (p_dev_hold)
		else $error("low bit too short");
	property p_start;
		$rose(sda_ctl_oe) && scl |-> !sda_dev_oe;
	endproperty
	a_start: assert property (p_start)
		else $error("start while data held");
	property p_stop;
		$fell(sda_ctl_oe) && scl |-> !sda_dev_oe ##1 sda;
	endproperty
	a_stop: assert property (p_stop)
		else $error("stop did not raise data");

	c_ack: cover property ($rose(sda_dev_oe));
	c_start: cover property ($rose(sda_ctl_oe) && scl);
	c_stop: cover property ($fell(sda_ctl_oe) && scl);
endmodule

// File: testbench/tb.sv
// Bench joining both ends over the link interface.
// Assumes the package, interface and design compile first.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import eep_pkg::*;

	logic        clk, rst_n, wp, c_valid, c_read, c_id, w_valid, sb_prev;
	logic [2:0]  strap, c_cs;
	logic [15:0] c_addr, base;
	logic [7:0]  c_len, w_data, rd_data;
	logic        c_ready, w_ready, rd_valid, done, nack;
	logic        standby, busy, locked;
	logic [7:0]  d[8];
	logic [7:0]  rq[$];
	int          num_errors, checks_done, seed, n_ack, n_rise;

	eep_bus_if u_eep_bus_if();
	eep_dev #(.PROG_CYCLES(4000)) u_eep_dev (.ref_clk_in(clk),
		.reset_n_in(rst_n), .ce_in(1'b1), .strap_in(strap), .wp_in(wp),
		.standby_out(standby), .busy_out(busy), .id_locked_out(locked),
		.link_io(u_eep_bus_if.dev));
	eep_ctl u_eep_ctl (.ref_clk_in(clk), .reset_n_in(rst_n), .ce_in(1'b1),
		.cmd_valid_in(c_valid), .cmd_ready_out(c_ready),
		.cmd_read_in(c_read), .cmd_id_in(c_id), .cmd_cs_in(c_cs),
		.cmd_addr_in(c_addr), .cmd_len_in(c_len), .wr_valid_in(w_valid),
		.wr_ready_out(w_ready), .wr_data_in(w_data),
		.rd_valid_out(rd_valid), .rd_data_out(rd_data),
		.done_out(done), .nack_out(nack), .link_io(u_eep_bus_if.ctl));
	eep_asserts u_eep_asserts (.ref_clk_in(clk), .reset_n_in(rst_n),
		.scl_ctl_o(u_eep_bus_if.scl_ctl_o),
		.scl_ctl_oe(u_eep_bus_if.scl_ctl_oe),
		.sda_ctl_o(u_eep_bus_if.sda_ctl_o),
		.sda_ctl_oe(u_eep_bus_if.sda_ctl_oe),
		.sda_dev_o(u_eep_bus_if.sda_dev_o),
		.sda_dev_oe(u_eep_bus_if.sda_dev_oe),
		.scl(u_eep_bus_if.scl), .sda(u_eep_bus_if.sda));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(negedge clk)
		if (rd_valid === 1'b1)
			rq.push_back(rd_data);

	task automatic finish_test();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [7:0] e,
		input logic [7:0] g);
		checks_done++;
		if (g !== e)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wait_for(ref logic s, input int lim);
		int n;
		n = 0;
		while (s !== 1'b1 && n < lim)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= lim)
		begin
			chk("wait", 8'h01, 8'h00);
			finish_test();
		end
	endtask

	task automatic issue(input logic r, input logic [2:0] cs,
		input logic [15:0] a, input logic [7:0] l);
		wait_for(c_ready, 40000);
		c_read = r;
		c_cs = cs;
		c_addr = a;
		c_len = l;
		c_valid = 1'b1;
		@(negedge clk);
		c_valid = 1'b0;
	endtask

	task automatic cmd(input logic r, input logic [2:0] cs,
		input logic [15:0] a, input logic [7:0] l);
		issue(r, cs, a, l);
		wait_for(done, 40000);
	endtask

	// Byte expected at a page offset after the wrapped fill
	function automatic logic [7:0] wrap_exp(input logic [6:0] ofs);
		wrap_exp = d[3'(ofs - base[6:0])];
	endfunction

	initial
	begin
		{rst_n, wp, c_valid, c_read, c_id, w_valid, c_cs} = '0;
		{c_addr, base, c_len, w_data} = '0;
		seed = $urandom(32'h61aa);
		strap = 3'($urandom);
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		// Fill FIFO, page write crossing the page end
		base = {9'($urandom), 7'h7c};
		foreach (d[i])
		begin
			d[i] = 8'($urandom);
			w_data = d[i];
			w_valid = 1'b1;
			@(negedge clk);
		end
		w_valid = 1'b0;
		chk("full", 8'h00, {7'h00, w_ready});
		cmd(1'b0, strap, base, 8'h08);
		chk("wr_nack", 8'h00, {7'h00, nack});
		wait_for(busy, 50);
		chk("standby", 8'h00, {7'h00, standby});
		// Read at once: polled until programming ends
		rq.delete();
		cmd(1'b1, strap, {base[15:7], 7'h00}, 8'h04);
		chk("rd_nack", 8'h00, {7'h00, nack});
		for (int i = 0; i < 4; i++)
			chk("wrap", wrap_exp(7'(i)), rq[i]);
		wait_for(standby, 200);
		chk("idle", 8'h01, {7'h00, standby});
		$display("test page write done");
		// Select mismatch: never acknowledged, polled until reset
		issue(1'b0, strap ^ 3'(1 + $urandom % 7), base, 8'h01);
		n_ack = 0;
		n_rise = 0;
		sb_prev = standby;
		repeat (4000)
		begin
			@(negedge clk);
			n_ack += int'(u_eep_bus_if.sda_dev_oe);
			n_rise += int'(standby & ~sb_prev);
			sb_prev = standby;
		end
		chk("cs_ack", 8'h00, {7'h00, n_ack != 0});
		chk("cs_idle", 8'h01, {7'h00, n_rise != 0});
		// Reset in mid-command abandons the polling
		rst_n = 1'b0;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		$display("test select done");
		// Protected write leaves the array alone
		wp = 1'b1;
		w_data = ~d[4];
		w_valid = 1'b1;
		@(negedge clk);
		w_valid = 1'b0;
		cmd(1'b0, strap, {base[15:7], 7'h00}, 8'h01);
		repeat (20) @(negedge clk);
		chk("wp_busy", 8'h00, {7'h00, busy});
		wp = 1'b0;
		rq.delete();
		cmd(1'b1, strap, {base[15:7], 7'h00}, 8'h01);
		chk("wp_data", d[4], rq[0]);
		$display("test protect done");
		// Lock the identification page, then a locked write
		c_id = 1'b1;
		w_data = 8'(1 << LOCK_DATA_BIT);
		w_valid = 1'b1;
		@(negedge clk);
		w_data = 8'($urandom);
		@(negedge clk);
		w_valid = 1'b0;
		cmd(1'b0, strap, 16'(1 << LOCK_ADDR_BIT), 8'h01);
		chk("id_locked", 8'h01, {7'h00, locked});
		cmd(1'b0, strap, 16'h0000, 8'h01);
		chk("id_nack", 8'h01, {7'h00, nack});
		c_id = 1'b0;
		$display("test id lock done");
		finish_test();
	end
endmodule
